// ===== rtl/dpdm_channel.sv
`timescale 1ns/10ps
`include "dpdm_regs.svh"

module dpdm_channel (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_ni,
  // slot timing
  input  wire logic       tick_i,
  input  wire logic [7:0] next_idx_i,
  // programmed count
  input  wire logic [7:0] count_i,
  // modulator output
  output logic            out_o
);

  dpdm_pkg::dpdm_ch_state_t s_q;
  dpdm_pkg::dpdm_ch_state_t s_d;
  logic [7:0]               eff_count;

  // ----------------------------------------------------------------------
  // slot decision
  // ----------------------------------------------------------------------
  // count taken at cycle start
  assign eff_count = (next_idx_i == 8'h00) ? count_i : s_q.count_q;

  always_comb begin
    s_d = s_q;
    if (tick_i) begin
      s_d.count_q = eff_count;
      s_d.out_q   = dpdm_pkg::dpdm_bitrev(next_idx_i) < eff_count;
    end
  end

  // reset leaves the output low with a zero count
  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign out_o = s_q.out_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  logic [8:0] acc_q;

  // high slots seen so far in the running cycle
  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      acc_q <= 9'h000;
    end else if (tick_i) begin
      acc_q <= (next_idx_i == 8'h00) ? 9'h000 : acc_q + {8'h00, s_q.out_q};
    end
  end

  a_zero_stays_low: assert property (@(posedge clk_i) disable iff (!rst_ni)
    (s_q.count_q == 8'h00) |-> !out_o)
    else $error("output high with a zero count");

  a_density_match: assert property (@(posedge clk_i) disable iff (!rst_ni)
    (tick_i && next_idx_i == 8'h00) |-> (acc_q + {8'h00, s_q.out_q}) == {1'b0, s_q.count_q})
    else $error("high slot total differs from count");

  a_spread_half: assert property (@(posedge clk_i) disable iff (!rst_ni)
    (tick_i && next_idx_i != 8'h00 && s_q.count_q == 8'h80) |=> out_o != $past(out_o))
    else $error("half count does not alternate");

endmodule

// ===== rtl/dpdm_pkg.sv
package dpdm_pkg;

  // ----------------------------------------------------------------------
  // source of the second pin
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DPDM_R2_GENOUT = 2'b00,
    DPDM_R2_MOD    = 2'b01,
    DPDM_R2_LATCH  = 2'b10
  } dpdm_route2_t;

  // state of one modulator channel
  typedef struct packed {
    logic [7:0] count_q;
    logic       out_q;
  } dpdm_ch_state_t;

  // state of the top level
  typedef struct packed {
    logic [7:0] div_q;
    logic [7:0] idx_q;
    logic [7:0] cnt_first_q;
    logic [7:0] cnt_secnd_q;
    logic       route1_q;
    logic [1:0] route2_q;
    logic [7:0] rdata_q;
  } dpdm_top_state_t;

  // bit reversal spreads slot numbers over the cycle
  function automatic logic [7:0] dpdm_bitrev(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

endpackage

// ===== rtl/dpdm_regs.svh
`ifndef DPDM_REGS_SVH
`define DPDM_REGS_SVH

// ----------------------------------------------------------------------
// register map (word index on the plain register port)
// ----------------------------------------------------------------------
`define DPDM_ADDR_W         2
`define DPDM_ADDR_CNT_FIRST 2'h0
`define DPDM_ADDR_CNT_SECND 2'h1
`define DPDM_ADDR_PIN_SEL   2'h2

// ----------------------------------------------------------------------
// pin_source_select fields and reset value
// ----------------------------------------------------------------------
`define DPDM_SEL_R1_BIT     0
`define DPDM_SEL_R2_HI      5
`define DPDM_SEL_R2_LO      4
`define DPDM_SEL_RESET      8'h01
`define DPDM_R1_RESET       1'h1
`define DPDM_R2_RESET       2'h0
`define DPDM_R2_BAD         2'h3

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define DPDM_CLK_PERIOD_NS  100
`define DPDM_SLOT_NS        992
`define DPDM_CYCLE_NS       254000
`define DPDM_SLOTS          256
`define DPDM_COUNT_W        8

`endif

// ===== rtl/dpdm_top.sv
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
`include "dpdm_regs.svh"

// What this block does
// - two channels, write-only 8-bit pulse counts
// - pattern repeats every 256 microsecond cycle at 10 MHz
// - each pulse lasts one 1.0 microsecond slot at 10 MHz for counts up to 128
// - pulses spread evenly across the cycle
// - high fraction equals count over 256
// - bit 0 routes first pin, set at reset
// - bits 5:4 pick second pin source
// - select register readable and writable

module dpdm_top #(
  // nearest whole clock count: 1.0 us slot, 256 us cycle at 10 MHz
  parameter int SLOT_CYC = (`DPDM_SLOT_NS + `DPDM_CLK_PERIOD_NS / 2) / `DPDM_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic       CLOCK_I,
  input  wire logic       NRST_I,
  // register port
  input  wire logic [1:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  // other pin sources
  input  wire logic       GEN_OUT1_I,
  input  wire logic       GEN_OUT2_I,
  input  wire logic       LATCH2_I,
  // package pins
  output logic            PIN1_O,
  output logic            PIN2_O
);

  // ----------------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------------
  // slot count must be at least one and fit the divider
  if (SLOT_CYC < 1 || SLOT_CYC > 255) begin : g_bad_slot
    $error("SLOT_CYC out of range");
  end
  // index width ties the cycle to 256 slots
  if (`DPDM_SLOTS != 256 || `DPDM_COUNT_W != 8) begin : g_bad_cycle
    $error("cycle must be 256 slots of 8-bit count");
  end

  localparam logic [7:0] SLOT_LAST = 8'(SLOT_CYC - 1);

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;

  // async assert, sync release through two stages
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  dpdm_pkg::dpdm_top_state_t s_q;
  dpdm_pkg::dpdm_top_state_t s_d;
  logic                      tick;
  logic [7:0]                next_idx;
  logic                      mod_first;
  logic                      mod_secnd;
  logic [7:0]                sel_view;

  // slot enable from the clock divider
  assign tick     = (s_q.div_q == SLOT_LAST);
  assign next_idx = s_q.idx_q + 8'h01;

  // select register as seen by software
  always_comb begin
    sel_view = 8'h00;
    sel_view[`DPDM_SEL_R1_BIT] = s_q.route1_q;
    sel_view[`DPDM_SEL_R2_HI:`DPDM_SEL_R2_LO] = s_q.route2_q;
  end

  // next state: divider, slot index, registers, read data
  always_comb begin
    s_d = s_q;
    s_d.div_q = tick ? 8'h00 : s_q.div_q + 8'h01;
    if (tick) begin
      s_d.idx_q = next_idx;
    end
    if (WR_I) begin
      unique case (ADDR_I)
        `DPDM_ADDR_CNT_FIRST: s_d.cnt_first_q = WDATA_I;
        `DPDM_ADDR_CNT_SECND: s_d.cnt_secnd_q = WDATA_I;
        `DPDM_ADDR_PIN_SEL: begin
          s_d.route1_q = WDATA_I[`DPDM_SEL_R1_BIT];
          if (WDATA_I[`DPDM_SEL_R2_HI:`DPDM_SEL_R2_LO] != `DPDM_R2_BAD) begin
            s_d.route2_q = WDATA_I[`DPDM_SEL_R2_HI:`DPDM_SEL_R2_LO];
          end
        end
        default: ;
      endcase
    end
    // counts are write-only and read as zero
    s_d.rdata_q = 8'h00;
    if (RD_I) begin
      if (ADDR_I == `DPDM_ADDR_PIN_SEL) begin
        s_d.rdata_q = sel_view;
      end
    end
  end

  // single register stage for all top state
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      s_q          <= '0;
      s_q.route1_q <= `DPDM_R1_RESET;
      s_q.route2_q <= `DPDM_R2_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign RDATA_O = s_q.rdata_q;

  // ----------------------------------------------------------------------
  // modulator channels
  // ----------------------------------------------------------------------
  // both share one slot timebase so their cycles stay aligned
  dpdm_channel u_first (
    .clk_i      (CLOCK_I),
    .rst_ni     (rst_n),
    .tick_i     (tick),
    .next_idx_i (next_idx),
    .count_i    (s_q.cnt_first_q),
    .out_o      (mod_first)
  );

  dpdm_channel u_secnd (
    .clk_i      (CLOCK_I),
    .rst_ni     (rst_n),
    .tick_i     (tick),
    .next_idx_i (next_idx),
    .count_i    (s_q.cnt_secnd_q),
    .out_o      (mod_secnd)
  );

  // ----------------------------------------------------------------------
  // pin multiplexers
  // ----------------------------------------------------------------------
  // first pin source
  assign PIN1_O = s_q.route1_q ? GEN_OUT1_I : mod_first;

  always_comb begin
    unique case (dpdm_pkg::dpdm_route2_t'(s_q.route2_q))
      dpdm_pkg::DPDM_R2_GENOUT: PIN2_O = GEN_OUT2_I;
      dpdm_pkg::DPDM_R2_MOD:    PIN2_O = mod_secnd;
      dpdm_pkg::DPDM_R2_LATCH:  PIN2_O = LATCH2_I;
      default:                  PIN2_O = 1'b0; // code 11 never stored
    endcase
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  // clocks since the last slot tick; slot length is a parameter, so count it
  logic [7:0] gap_q;

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= 8'h00;
    end else begin
      gap_q <= tick ? 8'h00 : gap_q + 8'h01;
    end
  end

  // a slot has run its full length
  sequence s_slot_due;
    gap_q == SLOT_LAST;
  endsequence

  a_slot_period: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    s_slot_due |-> tick)
    else $error("slot tick missing at slot end");

  a_slot_early: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    tick |-> s_slot_due)
    else $error("slot tick before slot end");

  a_cycle_wrap: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    (tick && s_q.idx_q == 8'hff) |=> (s_q.idx_q == 8'h00))
    else $error("cycle did not wrap after 256 slots");

  a_count_write: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    (WR_I && ADDR_I == `DPDM_ADDR_CNT_SECND)
    |=> (s_q.cnt_secnd_q == $past(WDATA_I)))
    else $error("second count not stored");

  a_first_route: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    PIN1_O == (s_q.route1_q ? GEN_OUT1_I : u_first.out_o))
    else $error("first pin source wrong");

  a_second_route: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    (s_q.route2_q == dpdm_pkg::DPDM_R2_MOD) |-> (PIN2_O == mod_secnd))
    else $error("second pin not on modulator");

  a_bad_code_kept: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    (WR_I && ADDR_I == `DPDM_ADDR_PIN_SEL
      && WDATA_I[`DPDM_SEL_R2_HI:`DPDM_SEL_R2_LO] == `DPDM_R2_BAD)
    |=> $stable(s_q.route2_q))
    else $error("invalid route code accepted");

  a_select_read: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    (RD_I && ADDR_I == `DPDM_ADDR_PIN_SEL && !WR_I)
    |=> (RDATA_O == {2'h0, $past(s_q.route2_q), 3'h0, $past(s_q.route1_q)}))
    else $error("select read back wrong");

  a_new_count_late: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    (tick && next_idx != 8'h00) |=> $stable(u_first.s_q.count_q))
    else $error("count changed mid cycle");

endmodule

// ===== test/dpdm_rc_load.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// filter load: integrates high time and longest burst seen on a pin
// ----------------------------------------------------------------------
module dpdm_rc_load (
  // clock and window clear
  input  wire logic        clk_i,
  input  wire logic        clr_i,
  // pin from the device
  input  wire logic        pin_i,
  // integrated high clocks and longest run
  output logic      [15:0] high_o,
  output logic      [15:0] run_o
);
  logic [15:0] cur_q;

  // a long burst means poor spreading, so the filter ripple grows
  always_ff @(posedge clk_i) begin
    if (clr_i) begin
      high_o <= 16'h0000;
      run_o  <= 16'h0000;
      cur_q  <= 16'h0000;
    end else if (pin_i === 1'b1) begin
      high_o <= high_o + 16'h0001;
      cur_q  <= cur_q + 16'h0001;
      if (cur_q + 16'h0001 > run_o) begin
        run_o <= cur_q + 16'h0001;
      end
    end else begin
      cur_q <= 16'h0000;
    end
  end
endmodule

// ===== test/tb.sv
`timescale 1ns/10ps
`include "dpdm_regs.svh"

`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin err_count++; \
  $display("ERROR %s expected %h seen %h", nm, ex, gt); end end

module tb;
  localparam int S   = 2;
  localparam int CYC = 256 * S;
  logic       clk, nrst, wr, rd, g1, g2, lat, clr;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, q;
  logic       pin1, pin2;
  logic [15:0] h1, h2, r1, r2;
  int         err_count, comparisons, seed;
  logic [7:0] n, m;

  // ----------------------------------------------------------------------
  // device, and one filter load on each pin
  // ----------------------------------------------------------------------
  dpdm_top #(.SLOT_CYC(S)) dut (.CLOCK_I(clk), .NRST_I(nrst), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .GEN_OUT1_I(g1),
    .GEN_OUT2_I(g2), .LATCH2_I(lat), .PIN1_O(pin1), .PIN2_O(pin2));
  dpdm_rc_load load1 (.clk_i(clk), .clr_i(clr), .pin_i(pin1), .high_o(h1), .run_o(r1));
  dpdm_rc_load load2 (.clk_i(clk), .clr_i(clr), .pin_i(pin2), .high_o(h2), .run_o(r2));

  // clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // register port write, one strobe cycle
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe edge
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // expected longest burst: bit-reversed spreading never pairs slots up to half
  function automatic logic [15:0] exp_run(input logic [7:0] c);
    return (c == 8'h00) ? 16'h0000 : ((c <= 8'h80) ? 16'(S) : 16'hffff);
  endfunction

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog, well beyond the ~12k cycles the tests need
  initial begin
    #5ms;
    err_count++;
    wrap_up();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    {wr, rd, clr, addr, wdata} = '0;
    seed = 32'ha1f8;
    {g1, g2, lat} = 3'($random(seed));
    err_count = 0;
    comparisons = 0;
    nrst = 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    // reset routing and readback
    rd_reg(`DPDM_ADDR_PIN_SEL, q);
    `CHK("sel reset", `DPDM_SEL_RESET, q)
    `CHK("pin1 genout", g1, pin1)
    `CHK("pin2 genout", g2, pin2)
    $display("test reset done");
    // latch route, then invalid code keeps field but takes bit 0
    wr_reg(`DPDM_ADDR_PIN_SEL, 8'h20);
    rd_reg(`DPDM_ADDR_PIN_SEL, q);
    `CHK("sel rw", 8'h20, q)
    repeat (2) begin
      @(posedge clk);
      lat <= ~lat;
      #1 `CHK("pin2 latch", lat, pin2)
    end
    wr_reg(`DPDM_ADDR_PIN_SEL, 8'h31);
    rd_reg(`DPDM_ADDR_PIN_SEL, q);
    `CHK("sel bad code", 8'h21, q)
    `CHK("pin1 genout2", g1, pin1)
    rd_reg(`DPDM_ADDR_CNT_FIRST, q);
    `CHK("count write only", 8'h00, q)
    rd_reg(2'h3, q);
    `CHK("unmapped", 8'h00, q)
    $display("test routing done");
    // both pins on the modulators, corner counts then random ones
    wr_reg(`DPDM_ADDR_PIN_SEL, 8'h10);
    for (int i = 0; i < 8; i++) begin
      case (i)
        0: n = 8'h00;
        1: n = 8'h01;
        2: n = 8'h80;
        3: n = 8'hff;
        default: n = 8'($random(seed));
      endcase
      m = ~n;
      wr_reg(`DPDM_ADDR_CNT_FIRST, n);
      wr_reg(`DPDM_ADDR_CNT_SECND, m);
      // a new count waits for the next cycle start
      repeat (2 * CYC) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (CYC) @(posedge clk);
      #1;
      `CHK("pin1 high time", 16'(n) * 16'(S), h1)
      `CHK("pin2 high time", 16'(m) * 16'(S), h2)
      if (n <= 8'h80) begin
        `CHK("pin1 spread", exp_run(n), r1)
      end
      if (m <= 8'h80) begin
        `CHK("pin2 spread", exp_run(m), r2)
      end
      $display("test count %h done", n);
    end
    wrap_up();
  end
endmodule
